// File: common/tone_ring_regs.vh
// Register map, fields and reset values of the tone and ringing bank.
`ifndef TONE_RING_REGS_VH
`define TONE_RING_REGS_VH

// --------------------
// Register indices and byte addresses, four times the index.
// --------------------
`define IDX_INDIRECT_ACCESS_STATUS 8'h1F
`define IDX_TONE_OSC_ONE_CONTROL   8'h20
`define IDX_TONE_OSC_TWO_CONTROL   8'h21
`define IDX_RINGING_OSC_CONTROL    8'h22
`define ADDR_INDIRECT_ACCESS_STATUS 12'h07C
`define ADDR_TONE_OSC_ONE_CONTROL   12'h080
`define ADDR_TONE_OSC_TWO_CONTROL   12'h084
`define ADDR_RINGING_OSC_CONTROL    12'h088

// --------------------
// Reset values
// --------------------
`define RST_INDIRECT_ACCESS_STATUS 8'h00
`define RST_TONE_OSC_ONE_CONTROL   8'h00
`define RST_TONE_OSC_TWO_CONTROL   8'h00
`define RST_RINGING_OSC_CONTROL    8'h00

// --------------------
// Field positions
// --------------------
`define BIT_INDIRECT_PENDING 0
`define BIT_ACTIVE_FLAG      7
`define BIT_AUTO_RELOAD      6
`define BIT_ZERO_CROSS_STOP  5
`define BIT_ON_TIMER_EN      4
`define BIT_OFF_TIMER_EN     3
`define BIT_OSC_ENABLE       2
`define BIT_ROUTE_HI         1
`define BIT_ROUTE_LO         0
`define BIT_RING_ON_LINE     5
`define BIT_RING_DC_OFFSET   1
`define BIT_RING_WAVE_SELECT 0

// Writable bit masks; every other bit is status or reserved.
`define WMASK_TONE_OSC_ONE 8'h7F
`define WMASK_TONE_OSC_TWO 8'h3F
`define WMASK_RINGING_OSC  8'h1B

`endif

// File: src/tone_ring_ctrl.v
// Tone and ringing oscillator control bank with an APB register slave.
//
// Register access over APB was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "tone_ring_regs.vh"

// --------------------
// Cadence sequencer shared by the three oscillators
// --------------------

module cadence_seq (
   input  wire       pclk,          // Bus clock.
   input  wire       presetn,       // Asynchronous reset, active low.
   input  wire       enable,        // Oscillator enable.
   input  wire       on_timer_en,   // Active timer enable.
   input  wire       off_timer_en,  // Inactive timer enable.
   input  wire       zc_stop,       // End the burst at a zero crossing.
   input  wire       reload,        // Restart the cadence after the off period.
   input  wire       on_expired,    // Active timer expiry pulse.
   input  wire       off_expired,   // Inactive timer expiry pulse.
   input  wire       zero_cross,    // Waveform zero crossing pulse.
   output wire       active,        // Output signal active.
   output wire       off_phase      // Inactive timer running.
);

   // Cadence states.
   localparam [2:0] S_IDLE     = 3'h0;
   localparam [2:0] S_ACTIVE   = 3'h1;
   localparam [2:0] S_DRAIN    = 3'h2;
   localparam [2:0] S_INACTIVE = 3'h3;
   localparam [2:0] S_DONE     = 3'h4;

   // Present and next cadence state.
   reg  [2:0] state_q;
   reg  [2:0] state_d;
   wire [2:0] after_burst;

   // Where a burst goes once it has ended: off period, or a final stop.
   assign after_burst = off_timer_en ? S_INACTIVE : S_DONE;

   // Next state; disabling the oscillator always returns it to idle.
   always @* begin
      state_d = state_q;
      case (state_q)
         S_IDLE: begin
            if (enable) state_d = S_ACTIVE;
         end
         S_ACTIVE: begin
            if (on_timer_en && on_expired) begin
               state_d = zc_stop ? S_DRAIN : after_burst; // RULE7 RULE8
            end
         end
         S_DRAIN: begin
            if (zero_cross) state_d = after_burst; // RULE7 RULE8
         end
         S_INACTIVE: begin
            if (off_expired) state_d = reload ? S_ACTIVE : S_DONE; // RULE4 RULE5
         end
         S_DONE: begin
            state_d = S_DONE;
         end
         default: begin
            state_d = S_IDLE;
         end
      endcase
      if (!enable) state_d = S_IDLE;
   end

   // State register.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= S_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // The signal stays on while it drains towards its zero crossing.
   assign active    = (state_q == S_ACTIVE) || (state_q == S_DRAIN);
   assign off_phase = (state_q == S_INACTIVE);

endmodule

// --------------------
// Top level: register bank and oscillator control
// --------------------

// Notes on behaviour
// (RULE1) Status bit 0 is 1 while an indirect access is pending; other bits zero.
// (RULE2) Address-only write loads indirect data at next update; pending until then.
// (RULE3) Tone one control bit 7 reads 1 while tone one output is active.
// (RULE4) Reload clear: tone one stops once its inactive timer expires.
// (RULE5) Reload set: tone one restarts its cadence instead of stopping.
// (RULE6) Software should set tone one reload when sending FSK signalling.
// (RULE7) Tone one bit 5 set ends burst at next zero crossing after expiry.
// (RULE8) Tone two bit 5 set ends burst at zero crossing, else on expiry.
// (RULE9) Tone one bits 4, 3, 2 enable active timer, inactive timer, oscillator.
// (RULE10) Tone two bits 4, 3, 2 enable active timer, inactive timer, oscillator.
// (RULE11) Tone one routing 00 none, 01 transmit, 10 receive, 11 both.
// (RULE12) Tone two routing uses the same steering codes.
// (RULE13) Tone two bit 7 reads active status; bit 6 reads zero.
// (RULE14) Ringing control bit 7 reads 1 while ringing output is active.
// (RULE15) Ringing reaches the line only when it meets the dc feed level.
// (RULE16) Ringing bit 5 reads 1 only while ringing is applied to the line.
// (RULE17) Ringing bits 4 and 3 enable the active and inactive cadence timers.
// (RULE18) Ringing bit 2 reads 1 while the ringing oscillator is enabled.
// (RULE19) Ringing bit 1 set adds a dc offset to the ringing waveform.
// (RULE20) Ringing bit 0 selects sinusoid at 0, trapezoid at 1.
// (RULE21) Writes to status and reserved bits are ignored.
module tone_ring_ctrl (
   input  wire        pclk,            // APB clock, 40 MHz.
   input  wire        presetn,         // Asynchronous reset, active low.
   input  wire        psel,            // APB select.
   input  wire        penable,         // APB access phase.
   input  wire        pwrite,          // APB write when high.
   input  wire [11:0] paddr,           // APB byte address.
   input  wire [31:0] pwdata,          // APB write data.
   output wire        pready,          // APB ready, always high.
   output wire [31:0] prdata,          // APB read data.
   output wire        pslverr,         // APB error on an unmapped address.
   input  wire        indirect_addr_wr,   // Pulse: indirect address written alone.
   input  wire        indirect_update,    // Pulse: indirect memory update tick.
   output wire        indirect_load,      // Pulse: load indirect data this tick.
   input  wire        tone1_on_expired,   // Pulse: tone one active timer expired.
   input  wire        tone1_off_expired,  // Pulse: tone one inactive timer expired.
   input  wire        tone1_zero_cross,   // Pulse: tone one waveform zero crossing.
   input  wire        tone2_on_expired,   // Pulse: tone two active timer expired.
   input  wire        tone2_off_expired,  // Pulse: tone two inactive timer expired.
   input  wire        tone2_zero_cross,   // Pulse: tone two waveform zero crossing.
   input  wire        ring_request,       // Level: linefeed asks for ringing.
   input  wire        ring_on_expired,    // Pulse: ringing active timer expired.
   input  wire        ring_off_expired,   // Pulse: ringing inactive timer expired.
   input  wire        ring_at_dc_level,   // Pulse: ringing waveform meets dc feed.
   output wire        tone1_tx_en,        // Tone one feeds the transmit path.
   output wire        tone1_rx_en,        // Tone one feeds the receive path.
   output wire        tone1_on_timer_run, // Tone one active timer counting.
   output wire        tone1_off_timer_run,// Tone one inactive timer counting.
   output wire        tone2_tx_en,        // Tone two feeds the transmit path.
   output wire        tone2_rx_en,        // Tone two feeds the receive path.
   output wire        tone2_on_timer_run, // Tone two active timer counting.
   output wire        tone2_off_timer_run,// Tone two inactive timer counting.
   output wire        ring_osc_run,       // Ringing oscillator producing output.
   output wire        ring_on_timer_run,  // Ringing active timer counting.
   output wire        ring_off_timer_run, // Ringing inactive timer counting.
   output wire        ring_drive_line,    // Ringing waveform applied to the line.
   output wire        ring_dc_offset,     // Add dc offset to ringing.
   output wire        ring_wave_select    // Ringing shape: 0 sine, 1 trapezoid.
);

   // --------------------
   // Bus decode
   // --------------------

   reg  [7:0]  tone1_ctrl_q;
   reg  [7:0]  tone2_ctrl_q;
   reg  [7:0]  ring_ctrl_q;
   reg         indirect_pending_q;
   reg         ring_osc_enabled_q;
   reg         ring_on_line_q;
   reg  [7:0]  rdata_byte;
   reg         addr_hit;
   wire        wr_en;
   wire        tone1_active_flag;
   wire        tone2_active_flag;
   wire        ring_active_flag;
   wire        tone1_off_phase;
   wire        tone2_off_phase;
   wire        ring_off_phase;

   // Zero wait states: each access completes in its first access cycle.
   assign pready  = 1'b1;
   assign wr_en   = psel && penable && pwrite && addr_hit;
   assign pslverr = psel && penable && !addr_hit;

   // Read multiplexer; status bits come from live state, reserved bits zero.
   always @* begin
      addr_hit   = 1'b1;
      rdata_byte = 8'h00;
      case (paddr)
         `ADDR_INDIRECT_ACCESS_STATUS: begin
            rdata_byte[`BIT_INDIRECT_PENDING] = indirect_pending_q; // RULE1
         end
         `ADDR_TONE_OSC_ONE_CONTROL: begin
            rdata_byte = tone1_ctrl_q & `WMASK_TONE_OSC_ONE;
            rdata_byte[`BIT_ACTIVE_FLAG] = tone1_active_flag; // RULE3
         end
         `ADDR_TONE_OSC_TWO_CONTROL: begin
            rdata_byte = tone2_ctrl_q & `WMASK_TONE_OSC_TWO;
            rdata_byte[`BIT_ACTIVE_FLAG] = tone2_active_flag; // RULE13
         end
         `ADDR_RINGING_OSC_CONTROL: begin
            rdata_byte = ring_ctrl_q & `WMASK_RINGING_OSC;
            rdata_byte[`BIT_ACTIVE_FLAG]  = ring_active_flag;   // RULE14
            rdata_byte[`BIT_RING_ON_LINE] = ring_on_line_q;     // RULE16
            rdata_byte[`BIT_OSC_ENABLE]   = ring_osc_enabled_q; // RULE18
         end
         default: begin
            addr_hit = 1'b0;
         end
      endcase
   end

   // Only the low byte carries a register.
   assign prdata = {24'h000000, rdata_byte};

   // --------------------
   // Control registers
   // --------------------

   // Writes keep only the writable bits, so status and reserved stay clean.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tone1_ctrl_q <= `RST_TONE_OSC_ONE_CONTROL;
         tone2_ctrl_q <= `RST_TONE_OSC_TWO_CONTROL;
         ring_ctrl_q  <= `RST_RINGING_OSC_CONTROL;
      end else if (wr_en) begin
         if (paddr == `ADDR_TONE_OSC_ONE_CONTROL) begin
            tone1_ctrl_q <= pwdata[7:0] & `WMASK_TONE_OSC_ONE; // RULE21
         end
         if (paddr == `ADDR_TONE_OSC_TWO_CONTROL) begin
            tone2_ctrl_q <= pwdata[7:0] & `WMASK_TONE_OSC_TWO; // RULE21
         end
         if (paddr == `ADDR_RINGING_OSC_CONTROL) begin
            ring_ctrl_q <= pwdata[7:0] & `WMASK_RINGING_OSC; // RULE21
         end
      end
   end

   // --------------------
   // Indirect access tracking
   // --------------------

   // A new address write in the update cycle keeps the access pending.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         indirect_pending_q <= 1'b0;
      end else if (indirect_addr_wr) begin
         indirect_pending_q <= 1'b1; // RULE2
      end else if (indirect_update) begin
         indirect_pending_q <= 1'b0; // RULE2
      end
   end

   // An address write in the tick defers the load.
   assign indirect_load = indirect_update && indirect_pending_q && !indirect_addr_wr; // RULE2

   // --------------------
   // Tone oscillators
   // --------------------

   cadence_seq u_tone1 (
      .pclk         (pclk),
      .presetn      (presetn),
      .enable       (tone1_ctrl_q[`BIT_OSC_ENABLE]),      // RULE9
      .on_timer_en  (tone1_ctrl_q[`BIT_ON_TIMER_EN]),     // RULE9
      .off_timer_en (tone1_ctrl_q[`BIT_OFF_TIMER_EN]),    // RULE9
      .zc_stop      (tone1_ctrl_q[`BIT_ZERO_CROSS_STOP]), // RULE7
      .reload       (tone1_ctrl_q[`BIT_AUTO_RELOAD]),     // RULE4 RULE5
      .on_expired   (tone1_on_expired),
      .off_expired  (tone1_off_expired),
      .zero_cross   (tone1_zero_cross),
      .active       (tone1_active_flag),
      .off_phase    (tone1_off_phase)
   );

   // Tone two has no reload bit; its cadence repeats while enabled with the inactive timer on.
   cadence_seq u_tone2 (
      .pclk         (pclk),
      .presetn      (presetn),
      .enable       (tone2_ctrl_q[`BIT_OSC_ENABLE]),      // RULE10
      .on_timer_en  (tone2_ctrl_q[`BIT_ON_TIMER_EN]),     // RULE10
      .off_timer_en (tone2_ctrl_q[`BIT_OFF_TIMER_EN]),    // RULE10
      .zc_stop      (tone2_ctrl_q[`BIT_ZERO_CROSS_STOP]), // RULE8
      .reload       (1'b1),
      .on_expired   (tone2_on_expired),
      .off_expired  (tone2_off_expired),
      .zero_cross   (tone2_zero_cross),
      .active       (tone2_active_flag),
      .off_phase    (tone2_off_phase)
   );

   // Output steering: low route bit selects transmit, high bit receive.
   assign tone1_tx_en = tone1_active_flag && tone1_ctrl_q[`BIT_ROUTE_LO]; // RULE11
   assign tone1_rx_en = tone1_active_flag && tone1_ctrl_q[`BIT_ROUTE_HI]; // RULE11
   assign tone2_tx_en = tone2_active_flag && tone2_ctrl_q[`BIT_ROUTE_LO]; // RULE12
   assign tone2_rx_en = tone2_active_flag && tone2_ctrl_q[`BIT_ROUTE_HI]; // RULE12

   // Active timers run only in their phase and when enabled; inactive timers run throughout the off phase.
   assign tone1_on_timer_run  = tone1_active_flag && tone1_ctrl_q[`BIT_ON_TIMER_EN];
   assign tone1_off_timer_run = tone1_off_phase;
   assign tone2_on_timer_run  = tone2_active_flag && tone2_ctrl_q[`BIT_ON_TIMER_EN];
   assign tone2_off_timer_run = tone2_off_phase;

   // --------------------
   // Ringing oscillator
   // --------------------

   // The ringing enable follows the linefeed request, one cycle late.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ring_osc_enabled_q <= 1'b0;
      end else begin
         ring_osc_enabled_q <= ring_request; // RULE18
      end
   end

   // Ringing has no zero-cross bit; its cadence repeats while enabled with the inactive timer on.
   cadence_seq u_ring (
      .pclk         (pclk),
      .presetn      (presetn),
      .enable       (ring_osc_enabled_q),
      .on_timer_en  (ring_ctrl_q[`BIT_ON_TIMER_EN]),  // RULE17
      .off_timer_en (ring_ctrl_q[`BIT_OFF_TIMER_EN]), // RULE17
      .zc_stop      (1'b0),
      .reload       (1'b1),
      .on_expired   (ring_on_expired),
      .off_expired  (ring_off_expired),
      .zero_cross   (1'b0),
      .active       (ring_active_flag),
      .off_phase    (ring_off_phase)
   );

   // Line hand-over waits for the waveform to meet the dc feed level both
   // when ringing starts and when it stops, so the line voltage never jumps.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ring_on_line_q <= 1'b0;
      end else if (ring_at_dc_level) begin
         ring_on_line_q <= ring_active_flag; // RULE15
      end
   end

   // Line, timer and shape outputs of the ringing path.
   assign ring_drive_line    = ring_on_line_q; // RULE16
   assign ring_osc_run       = ring_active_flag || ring_on_line_q;
   assign ring_on_timer_run  = ring_active_flag && ring_ctrl_q[`BIT_ON_TIMER_EN];
   assign ring_off_timer_run = ring_off_phase;
   assign ring_dc_offset     = ring_ctrl_q[`BIT_RING_DC_OFFSET];   // RULE19
   assign ring_wave_select   = ring_ctrl_q[`BIT_RING_WAVE_SELECT]; // RULE20

endmodule

`default_nettype wire

// File: tb/host_model.sv
// Host processor model that reaches the control bank over APB.
`timescale 1ns/100ps
`default_nettype none
`include "tone_ring_regs.vh"
// ------------------------------
// Host model
// ------------------------------
module host_model (
   input  wire logic        pclk,    // Bus clock.
   output var  logic        psel,    // Select.
   output var  logic        penable, // Access phase.
   output var  logic        pwrite,  // Write.
   output var  logic [11:0] paddr,   // Address.
   output var  logic [31:0] pwdata,  // Write data.
   input  wire logic        pready,  // Ready.
   input  wire logic [31:0] prdata,  // Read data.
   input  wire logic        pslverr  // Error.
);
   // Bus is idle from time zero.
   initial {psel, penable, pwrite, paddr, pwdata} = '0;
   // One transfer: setup, then access held until ready is sampled high.
   task xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
             output logic [31:0] rdat, output logic er);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rdat = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Keyed signalling always runs tone one with reload set.
   task send_fsk(input logic [1:0] route);
      logic [31:0] r;
      logic        e;
      xfer(1'b1, `ADDR_TONE_OSC_ONE_CONTROL, {24'h000000, 6'h17, route}, r, e);
   endtask
endmodule
`default_nettype wire

// File: tb/tone_ring_ctrl_props.sv
// Port assertions for the tone and ringing control bank.
`timescale 1ns/100ps
`default_nettype none
`include "tone_ring_regs.vh"
// ------------------------------
// Port checker
// ------------------------------
module tone_ring_ctrl_props (
   input wire logic        pclk,             // Clock.
   input wire logic        presetn,          // Reset, active low.
   input wire logic        psel,             // Select.
   input wire logic        penable,          // Access phase.
   input wire logic        pwrite,           // Write.
   input wire logic [11:0] paddr,            // Address.
   input wire logic [31:0] pwdata,           // Write data.
   input wire logic [31:0] prdata,           // Read data.
   input wire logic        pslverr,          // Error.
   input wire logic        indirect_addr_wr, // Address written.
   input wire logic        indirect_update,  // Update tick.
   input wire logic        indirect_load,    // Load pulse.
   input wire logic        tone1_tx_en,      // Tone one transmit.
   input wire logic        tone1_rx_en,      // Tone one receive.
   input wire logic        tone1_on_timer_run, // Tone one on timer.
   input wire logic        tone2_tx_en,      // Tone two transmit.
   input wire logic        ring_at_dc_level, // Ringing meets feed.
   input wire logic        ring_osc_run,     // Ringing running.
   input wire logic        ring_drive_line,  // Ringing on line.
   input wire logic        ring_dc_offset,   // Offset select.
   input wire logic        ring_wave_select  // Shape select.
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Decoded access phases and the register map.
   wire logic acc = psel & penable;
   wire logic wacc = acc & pwrite;
   wire logic mapped = paddr == `ADDR_INDIRECT_ACCESS_STATUS
      || paddr == `ADDR_TONE_OSC_ONE_CONTROL || paddr == `ADDR_TONE_OSC_TWO_CONTROL
      || paddr == `ADDR_RINGING_OSC_CONTROL;
   a_upper_zero: assert property (psel |-> prdata[31:8] == 24'h000000)
      else $error("Read data upper bits are not zero.");
   a_unmapped_err: assert property (acc && !mapped |-> pslverr && prdata == 32'h00000000)
      else $error("Unmapped access not refused.");
   a_load_follows: assert property (indirect_addr_wr ##1 (indirect_update && !indirect_addr_wr)
      |-> indirect_load)
      else $error("Pending access not loaded at update.");
   a_load_single: assert property (indirect_load |=> !indirect_load)
      else $error("Load repeated without a new address.");
   a_route_none: assert property (wacc && paddr == `ADDR_TONE_OSC_ONE_CONTROL
      && pwdata[1:0] == 2'b00 |=> !tone1_tx_en && !tone1_rx_en)
      else $error("Tone one routed while unassigned.");
   a_route_two: assert property (wacc && paddr == `ADDR_TONE_OSC_TWO_CONTROL
      && !pwdata[0] |=> !tone2_tx_en)
      else $error("Tone two on transmit path while not assigned.");
   a_tone1_stop: assert property (wacc && paddr == `ADDR_TONE_OSC_ONE_CONTROL
      && !pwdata[2] |=> ##1 !tone1_tx_en && !tone1_on_timer_run)
      else $error("Tone one still active after disable.");
   a_offset_bit: assert property (wacc && paddr == `ADDR_RINGING_OSC_CONTROL
      |=> ring_dc_offset == $past(pwdata[1]))
      else $error("Ringing offset does not follow control.");
   a_wave_bit: assert property (wacc && paddr == `ADDR_RINGING_OSC_CONTROL
      |=> ring_wave_select == $past(pwdata[0]))
      else $error("Ringing shape does not follow control.");
   a_line_at_dc: assert property ($changed(ring_drive_line) |-> $past(ring_at_dc_level))
      else $error("Ringing switched on line away from feed level.");
   a_line_osc: assert property ($rose(ring_drive_line) |-> $past(ring_osc_run))
      else $error("Ringing put on line while oscillator idle.");
endmodule
bind tone_ring_ctrl tone_ring_ctrl_props u_props (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .pslverr, .indirect_addr_wr, .indirect_update, .indirect_load,
   .tone1_tx_en, .tone1_rx_en, .tone1_on_timer_run, .tone2_tx_en, .ring_at_dc_level,
   .ring_osc_run, .ring_drive_line, .ring_dc_offset, .ring_wave_select);
`default_nettype wire

// File: tb/tone_ring_ctrl_test.sv
// Self-checking bench for the tone and ringing control bank.
`timescale 1ns/100ps
`default_nettype none
`include "tone_ring_regs.vh"
// ------------------------------
// Bench top
// ------------------------------
module tone_ring_ctrl_test;
   logic        pclk;
   logic        presetn;
   logic        ring_request;
   logic [10:0] ev;
   logic [31:0] r;
   logic        e;
   int          err_total;
   int          tests_run;
   wire logic   psel, penable, pwrite, pready, pslverr, indirect_load;
   wire logic [11:0] paddr;
   wire logic [31:0] pwdata, prdata;
   wire logic [13:0] o;
   // Clock of 25 ns.
   always #12.5 pclk = ~pclk;
   host_model host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
      .pslverr);
   tone_ring_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
      .prdata, .pslverr, .indirect_addr_wr(ev[0]), .indirect_update(ev[1]), .indirect_load,
      .tone1_on_expired(ev[2]), .tone1_off_expired(ev[3]),
      .tone1_zero_cross(ev[4]), .tone2_on_expired(ev[5]), .tone2_off_expired(ev[6]),
      .tone2_zero_cross(ev[7]), .ring_request, .ring_on_expired(ev[8]),
      .ring_off_expired(ev[9]), .ring_at_dc_level(ev[10]), .tone1_tx_en(o[0]),
      .tone1_rx_en(o[1]), .tone1_on_timer_run(o[2]), .tone1_off_timer_run(o[3]),
      .tone2_tx_en(o[4]), .tone2_rx_en(o[5]), .tone2_on_timer_run(o[6]),
      .tone2_off_timer_run(o[7]), .ring_osc_run(o[8]), .ring_on_timer_run(o[9]),
      .ring_off_timer_run(o[10]), .ring_drive_line(o[11]), .ring_dc_offset(o[12]),
      .ring_wave_select(o[13]));
   // Comparison, register access and event helpers.
   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic [11:0] a, input logic [7:0] d);
      host.xfer(1'b1, a, {24'h000000, d}, r, e);
   endtask
   task rd(input logic [11:0] a, input logic [7:0] exp);
      host.xfer(1'b0, a, 32'h00000000, r, e);
      chk(r, {24'h000000, exp});
   endtask
   task pulse(input int b);
      @(posedge pclk);
      ev[b] <= 1'b1;
      @(posedge pclk);
      ev[b] <= 1'b0;
      #1;
   endtask
   task step;
      @(posedge pclk);
      #1;
   endtask
   task tally_and_finish;
      $display("comparisons %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Reset values and a refused address.
   task t_reset;
      rd(`ADDR_INDIRECT_ACCESS_STATUS, 8'h00);
      rd(`ADDR_TONE_OSC_ONE_CONTROL, 8'h00);
      rd(`ADDR_TONE_OSC_TWO_CONTROL, 8'h00);
      rd(`ADDR_RINGING_OSC_CONTROL, 8'h00);
      host.xfer(1'b0, 12'h08C, 32'h00000000, r, e);
      chk(r, 32'h00000000);
      chk(32'({pready, e}), 32'h3);
      $display("reset test done");
   endtask
   // Pending flag across an address write and an update tick.
   task t_indirect;
      pulse(0);
      rd(`ADDR_INDIRECT_ACCESS_STATUS, 8'h01);
      wr(`ADDR_INDIRECT_ACCESS_STATUS, 8'hFF);
      rd(`ADDR_INDIRECT_ACCESS_STATUS, 8'h01);
      @(posedge pclk);
      ev[0] <= 1'b1;
      @(posedge pclk);
      ev[1] <= 1'b1;
      #1 chk(32'(indirect_load), 32'h0);
      @(posedge pclk);
      ev[0] <= 1'b0;
      #1 chk(32'(indirect_load), 32'h1);
      @(posedge pclk);
      ev[1] <= 1'b0;
      #1 rd(`ADDR_INDIRECT_ACCESS_STATUS, 8'h00);
      $display("indirect test done");
   endtask
   // Every routing code, then an expiry ignored with the timer off.
   task t_route;
      for (int i = 0; i < 4; i++) begin
         wr(`ADDR_TONE_OSC_ONE_CONTROL, 8'h14 | i[7:0]);
         step;
         chk(32'(o[3:0]), 32'h4 | i);
         rd(`ADDR_TONE_OSC_ONE_CONTROL, 8'h94 | i[7:0]);
      end
      wr(`ADDR_TONE_OSC_ONE_CONTROL, 8'h05);
      step;
      pulse(2);
      chk(32'(o[3:0]), 32'h1);
      $display("routing test done");
   endtask
   // Zero-cross ending and stop without reload, then reload.
   task t_cadence;
      wr(`ADDR_TONE_OSC_ONE_CONTROL, 8'h00);
      wr(`ADDR_TONE_OSC_ONE_CONTROL, 8'h3D);
      step;
      chk(32'(o[3:0]), 32'h5);
      pulse(2);
      chk(32'(o[3:0]), 32'h5);
      pulse(4);
      chk(32'(o[3:0]), 32'h8);
      pulse(3);
      chk(32'(o[3:0]), 32'h0);
      rd(`ADDR_TONE_OSC_ONE_CONTROL, 8'h3D);
      wr(`ADDR_TONE_OSC_ONE_CONTROL, 8'h00);
      host.send_fsk(2'b01);
      step;
      pulse(2);
      chk(32'(o[3:0]), 32'h8);
      pulse(3);
      chk(32'(o[3:0]), 32'h5);
      rd(`ADDR_TONE_OSC_ONE_CONTROL, 8'hDD);
      $display("cadence test done");
   endtask
   // Second oscillator with all writable bits set.
   task t_tone2;
      wr(`ADDR_TONE_OSC_TWO_CONTROL, 8'hFF);
      step;
      chk(32'(o[7:4]), 32'h7);
      rd(`ADDR_TONE_OSC_TWO_CONTROL, 8'hBF);
      pulse(5);
      chk(32'(o[7:4]), 32'h7);
      pulse(7);
      chk(32'(o[7:4]), 32'h8);
      pulse(6);
      chk(32'(o[7:4]), 32'h7);
      wr(`ADDR_TONE_OSC_TWO_CONTROL, 8'h00);
      $display("tone two test done");
   endtask
   // Ringing start and stop against the feed level.
   task t_ring;
      wr(`ADDR_RINGING_OSC_CONTROL, 8'hFF);
      step;
      chk(32'(o[13:12]), 32'h3);
      rd(`ADDR_RINGING_OSC_CONTROL, 8'h1B);
      ring_request <= 1'b1;
      repeat (2) step;
      chk(32'(o[11:8]), 32'h3);
      pulse(8);
      chk(32'(o[11:8]), 32'h4);
      pulse(9);
      chk(32'(o[11:8]), 32'h3);
      rd(`ADDR_RINGING_OSC_CONTROL, 8'h9F);
      pulse(10);
      rd(`ADDR_RINGING_OSC_CONTROL, 8'hBF);
      ring_request <= 1'b0;
      repeat (3) step;
      chk(32'(o[11:8]), 32'h9);
      rd(`ADDR_RINGING_OSC_CONTROL, 8'h3B);
      pulse(10);
      rd(`ADDR_RINGING_OSC_CONTROL, 8'h1B);
      wr(`ADDR_RINGING_OSC_CONTROL, 8'h00);
      step;
      chk(32'(o[13:12]), 32'h0);
      $display("ringing test done");
   endtask
   // Reset, then the scenarios in turn.
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      ring_request = 1'b0;
      ev = 11'h000;
      err_total = 0;
      tests_run = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_indirect;
      t_route;
      t_cadence;
      t_tone2;
      t_ring;
      tally_and_finish;
   end
   // Cuts a hang short well beyond the 165 or so cycles the run needs.
   initial begin
      repeat (5000) @(posedge pclk);
      err_total++;
      tally_and_finish;
   end
endmodule
`default_nettype wire
